/* File: rtl/debug_breakpoint_unit.sv */
// Purpose: breakpoint opcode, single-step and address breakpoint logic
// Assumes: the core never presents fetch and retire in the same cycle
// Notes: one exception request per cycle, registered
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module debug_breakpoint_unit
   import dbg_pkg::*;
#(
   parameter logic [7:0] PRIV_FAULT_VECTOR = 8'h0D
)
(
   input wire logic CORE_CLK,
   input wire logic RSTN,
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   input wire dbg_pkg::fetch_t FETCH,
   input wire dbg_pkg::data_access_t DATA,
   input wire dbg_pkg::retire_t RETIRE,
   output dbg_pkg::exc_t EXC
);
   import dbg_pkg::*;

   logic [31:0] bp_addr [NUM_BP];
   logic [31:0] control;
   logic [31:0] status;
   logic step_armed;
   logic data_pend;
   logic [NUM_BP-1:0] exec_hit;
   logic [NUM_BP-1:0] data_hit;
   logic [NUM_BP-1:0] enabled;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [31:0] wr_mask;
   logic [31:0] rd_data;
   exc_t next_exc;

   ////////////////////////////////////////////////////////////////////////
   // comparators, one per breakpoint address
   for (genvar i = 0; i < NUM_BP; i++)
   begin : g_bp
      // addresses arrive already linear; no translated address is seen
      bp_comparator u_cmp (
         .base(bp_addr[i]),
         .len(control[CTL_LEN_LSB + CTL_STRIDE*i +: 2]),
         .rw(control[CTL_RW_LSB + CTL_STRIDE*i +: 2]),
         .fetch(FETCH),
         .data(DATA),
         .exec_hit(exec_hit[i]),
         .data_hit(data_hit[i])
      );
      assign enabled[i] = control[2*i] | control[2*i+1];
   end

   wire exec_any = |(exec_hit & enabled);
   wire data_any = |(data_hit & enabled);
   // disabled matches ride along only when some enabled one fires
   wire [NUM_BP-1:0] hit_set = (exec_any || data_any)
      ? (exec_hit | data_hit) : '0;
   wire step_trap = RETIRE.valid && step_armed;
   wire data_trap = RETIRE.valid && (data_pend || data_any);
   wire break_trap = RETIRE.valid
      && RETIRE.opcode == BREAK_OPCODE;
   wire int_ok = !RETIRE.io_checked_mode || RETIRE.io_priv_ok;
   wire soft_int = RETIRE.valid && RETIRE.soft_int;

   ////////////////////////////////////////////////////////////////////////
   // bus decode
   wire wr_bp = wr_addr < ADDR_STATUS && wr_addr[1:0] == 2'h0;
   wire wr_status = wr_addr == ADDR_STATUS;
   wire wr_control = wr_addr == ADDR_CONTROL;
   wire wr_ok = wr_bp || wr_status || wr_control;
   wire rd_bp = ARADDR < ADDR_STATUS && ARADDR[1:0] == 2'h0;
   wire rd_ok = rd_bp || ARADDR == ADDR_STATUS || ARADDR == ADDR_CONTROL;
   assign rd_data = rd_bp ? bp_addr[ARADDR[3:2]] :
      (ARADDR == ADDR_STATUS) ? status : control;

   axil_port u_bus (
      .CORE_CLK(CORE_CLK),
      .RSTN(RSTN),
      .AWADDR(AWADDR),
      .AWVALID(AWVALID),
      .AWREADY(AWREADY),
      .WDATA(WDATA),
      .WSTRB(WSTRB),
      .WVALID(WVALID),
      .WREADY(WREADY),
      .BRESP(BRESP),
      .BVALID(BVALID),
      .BREADY(BREADY),
      .ARADDR(ARADDR),
      .ARVALID(ARVALID),
      .ARREADY(ARREADY),
      .RDATA(RDATA),
      .RRESP(RRESP),
      .RVALID(RVALID),
      .RREADY(RREADY),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_mask(wr_mask),
      .wr_ok(wr_ok),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );

   wire [31:0] merged_status = (status & ~wr_mask) | (wr_data & wr_mask);
   wire [31:0] merged_control = (control & ~wr_mask) | (wr_data & wr_mask);
   wire [31:0] local_keep = ~(32'h00000055 | (32'h1 << CTL_LE_BIT));
   // hardware sets win over a clearing write in the same cycle
   wire [31:0] next_status = ((wr_en && wr_status) ? merged_status : status)
      | {28'h0, hit_set}
      | (step_trap ? (32'h1 << STATUS_STEP_BIT) : 32'h0);
   // globals and global exact match survive a task switch
   wire [31:0] next_control = ((wr_en && wr_control) ? merged_control
      : control) & ((RETIRE.valid && RETIRE.task_switch) ? local_keep
      : 32'hFFFFFFFF);

   ////////////////////////////////////////////////////////////////////////
   // exception selection: fault before the instruction, traps merged after
   always_comb
   begin
      next_exc = '0;
      if (exec_any)
      begin
         next_exc.valid = 1'b1;
         next_exc.fault = 1'b1;
         next_exc.vector = VEC_DEBUG;
         next_exc.return_pointer = FETCH.addr;
      end
      else if (step_trap || data_trap)
      begin
         next_exc.valid = 1'b1;
         next_exc.vector = VEC_DEBUG;
         next_exc.return_pointer = RETIRE.next_pointer;
      end
      else if (break_trap)
      begin
         next_exc.valid = 1'b1;
         next_exc.vector = VEC_BREAK;
         next_exc.return_pointer = RETIRE.next_pointer;
      end
      else if (soft_int)
      begin
         next_exc.valid = 1'b1;
         next_exc.priv_fault = !int_ok;
         next_exc.fault = !int_ok;
         next_exc.vector = int_ok ? RETIRE.int_vector : PRIV_FAULT_VECTOR;
         next_exc.return_pointer = RETIRE.next_pointer;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state
   always_ff @(posedge CORE_CLK)
   begin
      if (!RSTN)
      begin
         control <= CONTROL_RESET;
         status <= STATUS_RESET;
         step_armed <= 1'b0;
         data_pend <= 1'b0;
         EXC <= '0;
      end
      else
      begin
         control <= next_control;
         status <= next_status;
         EXC <= next_exc;
         // flag as left by this instruction traps after the next one
         if (RETIRE.valid)
            step_armed <= RETIRE.flags[TF_BIT];
         data_pend <= (data_pend || data_any) && !data_trap;
      end
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (!RSTN)
         bp_addr <= '{default: BP_ADDR_RESET};
      else if (wr_en && wr_bp)
         bp_addr[wr_addr[3:2]] <= (bp_addr[wr_addr[3:2]] & ~wr_mask)
            | (wr_data & wr_mask);
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RSTN);

   a_reset_disabled: assert property (
      $rose(RSTN) |-> enabled == '0 && !EXC.valid)
      else $error("breakpoint enabled after reset");
   a_exec_fault: assert property (
      exec_any |=> EXC.valid && EXC.fault && EXC.vector == VEC_DEBUG
      && EXC.return_pointer == $past(FETCH.addr))
      else $error("execution breakpoint not a debug fault");
   a_data_trap: assert property (
      data_any && !RETIRE.valid && !exec_any
      ##1 !RETIRE.valid && !exec_any
      ##1 RETIRE.valid && !exec_any
      |=> EXC.valid && !EXC.fault && EXC.vector == VEC_DEBUG)
      else $error("data breakpoint trap missing");
   a_break_vector: assert property (
      break_trap && !exec_any && !step_trap && !data_trap
      |=> EXC.vector == VEC_BREAK && !EXC.fault && !EXC.priv_fault)
      else $error("breakpoint opcode not trap 3");
   a_step_follow: assert property (
      RETIRE.valid && RETIRE.flags[TF_BIT] ##1 !RETIRE.valid
      ##1 RETIRE.valid && !exec_any
      |=> EXC.vector == VEC_DEBUG && status[STATUS_STEP_BIT])
      else $error("single step trap not after next instruction");
   a_step_pointer: assert property (
      step_trap && !exec_any
      |=> EXC.return_pointer == $past(RETIRE.next_pointer))
      else $error("single step saved wrong pointer");
   a_hit_sticky: assert property (
      !(wr_en && wr_status) |=> (status[3:0] & $past(status[3:0]))
      == $past(status[3:0]))
      else $error("hit flag cleared by hardware");
   a_task_clear: assert property (
      RETIRE.valid && RETIRE.task_switch |=> control[0] == 1'b0
      && control[CTL_LE_BIT] == 1'b0
      && control[CTL_GE_BIT] == $past(control[CTL_GE_BIT]))
      else $error("task switch enable handling wrong");
   a_bad_len: assert property (
      control[CTL_LEN_LSB + CTL_STRIDE +: 2] == LEN_BAD
      |-> !exec_hit[1] && !data_hit[1])
      else $error("undefined length matched");
   a_disabled_quiet: assert property (
      enabled == '0 && !RETIRE.valid |=> !EXC.valid)
      else $error("exception with breakpoints disabled");
   a_enable_gate: assert property (
      (exec_hit & enabled) == '0 && !RETIRE.valid
      |=> !EXC.valid)
      else $error("disabled breakpoint raised exception");
   a_debug_vector: assert property (
      exec_any || step_trap || data_trap
      |=> EXC.valid && EXC.vector == VEC_DEBUG)
      else $error("debug event not on vector 1");
   a_trap_pointer: assert property (
      data_trap && !exec_any
      |=> !EXC.fault && EXC.return_pointer == $past(RETIRE.next_pointer))
      else $error("data trap not taken after the instruction");
   a_hit_set: assert property (
      exec_any || data_any
      |=> (status[3:0] & $past(exec_hit | data_hit))
      == $past(exec_hit | data_hit))
      else $error("matching hit flag not set");
   a_hit_quiet: assert property (
      !exec_any && !data_any && !(wr_en && wr_status)
      |=> status[3:0] == $past(status[3:0]))
      else $error("hit flag set without enabled match");
   a_exec_exact: assert property (
      exec_hit[0] |-> FETCH.addr == bp_addr[0]
      && control[CTL_RW_LSB +: 2] == RW_EXEC)
      else $error("execution match off first byte");
   // breakpoint one carries the data tests, so its fields are watched
   a_region_align: assert property (
      data_hit[1] |-> DATA.addr <= (bp_addr[1] | 32'h00000003)
      && {1'b0, DATA.addr} + {31'h0, DATA.size}
      >= {1'b0, bp_addr[1] & ~32'h00000003})
      else $error("data match outside aligned region");
   a_byte_len: assert property (
      data_hit[1] && control[CTL_LEN_LSB + CTL_STRIDE +: 2] == LEN_BYTE
      |-> DATA.addr <= bp_addr[1]
      && {1'b0, DATA.addr} + {31'h0, DATA.size} >= {1'b0, bp_addr[1]})
      else $error("byte breakpoint matched outside its byte");
   a_write_only: assert property (
      control[CTL_RW_LSB + CTL_STRIDE +: 2] == RW_WRITE
      && DATA.valid && !DATA.write |-> !data_hit[1])
      else $error("write-only breakpoint hit on read");
   a_exec_no_data: assert property (
      control[CTL_RW_LSB +: 2] == RW_EXEC |-> !data_hit[0])
      else $error("execution breakpoint hit on data");
   a_step_status: assert property (
      step_trap |=> status[STATUS_STEP_BIT])
      else $error("single step status flag not set");
   a_trap_once: assert property (
      data_trap && break_trap && !exec_any
      |=> EXC.valid && EXC.vector == VEC_DEBUG && !EXC.fault)
      else $error("coinciding traps not merged into vector 1");

   c_exec_fault: cover property (exec_any ##1 EXC.fault);
   c_data_trap: cover property (data_any ##[1:4] data_trap);
   c_step_trap: cover property (step_trap ##1 EXC.valid);
   c_task_switch: cover property (RETIRE.valid && RETIRE.task_switch);
   c_break_trap: cover property (break_trap ##1 EXC.valid);
endmodule // debug_breakpoint_unit
`default_nettype wire

/* File: inc/dbg_pkg.sv */
// Purpose: constants and carrier types for the debug breakpoint unit
// Assumes: one core clock, synchronous active-low reset
// Notes: offsets are byte addresses on the register bus
// Operation
// - executing opcode CC raises exception 3 as a trap after it completes.
// - opcode CC ignores io privilege; two-byte soft interrupt is checked.
// - single-step flag bit 8 set at instruction end raises exception 1.
// - single-step trap comes after the instruction following the setter.
// - single-step trap saves pointer to next unexecuted instruction.
// - reset leaves all four breakpoints disabled.
// - every debug register breakpoint goes to exception 1.
// - four 32-bit addresses compared against every linear address.
// - comparison uses linear addresses, never translated ones.
// - length 00 byte, 01 word ignores bit 0, 11 dword; 10 undefined.
// - word and dword regions are naturally aligned.
// - access 00 execute, 01 data write, 11 data read or write.
// - execution breakpoint is a fault, data breakpoint a trap.
// - partial or full overlap with region detects a data breakpoint.
// - breakpoint active only if its global or local enable is set.
// - task switch clears local enables and local exact match only.
// - enabled match sets hit flags of all matching; hardware never clears.
`default_nettype none
package dbg_pkg;
   localparam int NUM_BP = 4;
   localparam logic [7:0] ADDR_BP0 = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_CONTROL = 8'h14;
   localparam logic [31:0] BP_ADDR_RESET = 32'h00000000;
   localparam logic [31:0] CONTROL_RESET = 32'h00000000;
   localparam logic [31:0] STATUS_RESET = 32'h00000000;
   localparam int CTL_LE_BIT = 8;
   localparam int CTL_GE_BIT = 9;
   localparam int CTL_RW_LSB = 16;
   localparam int CTL_LEN_LSB = 18;
   localparam int CTL_STRIDE = 4;
   localparam int STATUS_STEP_BIT = 14;
   localparam int TF_BIT = 8;
   localparam logic [1:0] LEN_BYTE = 2'h0;
   localparam logic [1:0] LEN_WORD = 2'h1;
   localparam logic [1:0] LEN_BAD = 2'h2;
   localparam logic [1:0] LEN_DWORD = 2'h3;
   localparam logic [1:0] RW_EXEC = 2'h0;
   localparam logic [1:0] RW_WRITE = 2'h1;
   localparam logic [1:0] RW_RDWR = 2'h3;
   localparam logic [7:0] BREAK_OPCODE = 8'hCC;
   localparam logic [7:0] VEC_DEBUG = 8'h01;
   localparam logic [7:0] VEC_BREAK = 8'h03;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic valid;
      logic [31:0] addr;
   } fetch_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [1:0] size;
      logic [31:0] addr;
   } data_access_t;

   typedef struct packed {
      logic valid;
      logic [7:0] opcode;
      logic soft_int;
      logic [7:0] int_vector;
      logic io_checked_mode;
      logic io_priv_ok;
      logic task_switch;
      logic [31:0] flags;
      logic [31:0] next_pointer;
   } retire_t;

   typedef struct packed {
      logic valid;
      logic fault;
      logic priv_fault;
      logic [7:0] vector;
      logic [31:0] return_pointer;
   } exc_t;
endpackage
`default_nettype wire

/* File: rtl/bp_comparator.sv */
// Purpose: one linear address breakpoint comparator
// Assumes: data size is byte count minus one
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module bp_comparator
   import dbg_pkg::*;
(
   input wire logic [31:0] base,
   input wire logic [1:0] len,
   input wire logic [1:0] rw,
   input wire dbg_pkg::fetch_t fetch,
   input wire dbg_pkg::data_access_t data,
   output logic exec_hit,
   output logic data_hit
);
   wire [31:0] span;
   wire [31:0] lo;
   wire [31:0] hi;
   wire [32:0] acc_hi;
   wire len_ok;
   wire use_ok;

   ////////////////////////////////////////////////////////////////////////
   // low bits dropped from the base keep regions aligned
   assign span = (len == LEN_WORD) ? 32'h00000001 :
      (len == LEN_DWORD) ? 32'h00000003 : 32'h00000000;
   assign lo = base & ~span;
   assign hi = base | span;
   assign acc_hi = {1'b0, data.addr} + {31'h0, data.size};
   assign len_ok = (len != LEN_BAD);
   assign use_ok = (rw == RW_RDWR) || (rw == RW_WRITE && data.write);
   // exact first byte only, the fetch address includes prefixes
   assign exec_hit = fetch.valid && rw == RW_EXEC && len_ok
      && fetch.addr == base;
   // any overlap counts, so an access straddling the region still hits
   assign data_hit = data.valid && use_ok && len_ok
      && {1'b0, lo} <= acc_hi && data.addr <= hi;
endmodule // bp_comparator
`default_nettype wire

/* File: rtl/axil_port.sv */
// Purpose: AXI4-Lite slave handshake for a small register file
// Assumes: one write and one read outstanding at most
// Notes: write strobe fires in the first cycle that both address and data are held
`timescale 1ns/1ps
`default_nettype none
module axil_port
   import dbg_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RSTN,
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   output logic wr_en,
   output logic [7:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [31:0] wr_mask,
   input wire logic wr_ok,
   input wire logic [31:0] rd_data,
   input wire logic rd_ok
);
   logic aw_held;
   logic w_held;
   logic [3:0] strb;
   wire aw_take;
   wire w_take;
   wire ar_take;

   assign AWREADY = !aw_held && !BVALID;
   assign WREADY = !w_held && !BVALID;
   assign ARREADY = !RVALID;
   assign aw_take = AWVALID && AWREADY;
   assign w_take = WVALID && WREADY;
   assign ar_take = ARVALID && ARREADY;
   assign wr_en = aw_held && w_held && !BVALID;
   assign wr_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};

   always_ff @(posedge CORE_CLK)
   begin
      if (!RSTN)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 32'h00000000;
         strb <= 4'h0;
         BVALID <= 1'b0;
         BRESP <= RESP_OKAY;
      end
      else
      begin
         if (aw_take)
         begin
            aw_held <= 1'b1;
            wr_addr <= AWADDR;
         end
         if (w_take)
         begin
            w_held <= 1'b1;
            wr_data <= WDATA;
            strb <= WSTRB;
         end
         if (wr_en)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            BVALID <= 1'b1;
            BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (BVALID && BREADY)
            BVALID <= 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (!RSTN)
      begin
         RVALID <= 1'b0;
         RDATA <= 32'h00000000;
         RRESP <= RESP_OKAY;
      end
      else if (ar_take)
      begin
         RVALID <= 1'b1;
         RDATA <= rd_ok ? rd_data : 32'h00000000;
         RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (RVALID && RREADY)
         RVALID <= 1'b0;
   end
endmodule // axil_port
`default_nettype wire

/* File: verif/core_model.sv */
// Purpose: core pipeline model driving the fetch, data and retire ports
// Assumes: the bench calls one task at a time
// Notes: a released field shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module core_model
   import dbg_pkg::*;
(
   input wire logic core_clk,
   output var dbg_pkg::fetch_t fetch,
   output var dbg_pkg::data_access_t data,
   output var dbg_pkg::retire_t retire
);
   initial fetch = '0;
   initial data = '0;
   initial retire = '0;
   ////////////////////////////////////////////////////////////////////////
   // address of the first byte, prefixes included
   task automatic do_fetch(input logic [31:0] a);
      @(posedge core_clk);
      fetch <= {1'b1, a};
      @(posedge core_clk);
      fetch <= {1'b0, ~a};
   endtask
   // linear address, never a translated one
   task automatic do_data(input logic [31:0] a, input logic w,
      input logic [1:0] sz);
      @(posedge core_clk);
      data <= {1'b1, w, sz, a};
      @(posedge core_clk);
      data <= {1'b0, ~w, ~sz, ~a};
   endtask
   // flags carry the value left behind by the completed instruction
   task automatic do_retire(input dbg_pkg::retire_t r);
      dbg_pkg::retire_t idle;
      idle = ~r;
      idle.valid = 1'b0;
      @(posedge core_clk);
      retire <= r;
      @(posedge core_clk);
      retire <= idle;
   endtask
endmodule // core_model
`default_nettype wire

/* File: verif/debug_breakpoint_unit_tb_top.sv */
// Purpose: self-checking bench for the debug breakpoint unit
// Assumes: register map and latencies as handed over by the designer
// Notes: random values come from a fixed-seed shift register
`timescale 1ns/1ps
`default_nettype none
module debug_breakpoint_unit_tb_top;
   import dbg_pkg::*;
   localparam logic [7:0] priv_vec = 8'h2E;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   fetch_t fetch;
   data_access_t data;
   retire_t retire;
   exc_t exc;
   int miscompares = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [31:0] lfsr = 32'h494B;
   always #10 core_clk = ~core_clk;
   debug_breakpoint_unit #(.PRIV_FAULT_VECTOR(priv_vec)) dut_u (
      .CORE_CLK(core_clk), .RSTN(rstn), .AWADDR(awaddr), .AWVALID(awvalid),
      .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
      .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
      .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
      .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .FETCH(fetch),
      .DATA(data), .RETIRE(retire), .EXC(exc));
   core_model core_u (.core_clk(core_clk), .fetch(fetch), .data(data),
      .retire(retire));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   // region starts aligned because the length code masks the low bits
   function automatic logic exp_hit(input logic [31:0] b,
      input logic [1:0] l, input logic [31:0] a, input logic [1:0] s);
      logic [31:0] lo;
      lo = b & ~{30'h0, l};
      return (l != LEN_BAD) && (a <= lo + {30'h0, l}) &&
         (a + {30'h0, s} >= lo);
   endfunction
   function automatic retire_t mk_ret(input logic [7:0] op,
      input logic si, input logic ok, input logic ts, input logic tf,
      input logic [31:0] np);
      retire_t r;
      r = '0;
      r.valid = 1'b1;
      r.opcode = op;
      r.soft_int = si;
      r.int_vector = VEC_BREAK;
      r.io_checked_mode = 1'b1;
      r.io_priv_ok = ok;
      r.task_switch = ts;
      r.flags[TF_BIT] = tf;
      r.next_pointer = np;
      return r;
   endfunction
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic chk_exc(input logic [7:0] vec);
      check({23'h0, exc.valid, exc.vector}, {23'h0, 1'b1, vec});
   endtask
   task automatic no_exc();
      check({31'h0, exc.valid}, 32'h0);
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] rs);
      logic aw;
      logic w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw && w))
      begin
         @(posedge core_clk);
         if (awvalid && awready)
         begin
            aw = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready)
         begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (!bvalid)
         @(posedge core_clk);
      rs = bresp;
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] rs);
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge core_clk); while (!arready);
      arvalid <= 1'b0;
      while (!rvalid)
         @(posedge core_clk);
      d = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   task automatic summarize();
      if (miscompares == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // the whole sequence needs a few hundred cycles
   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         miscompares = miscompares + 1;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial
   begin : main
      logic [31:0] d, a, base, p;
      logic [1:0] rs, sz;
      retire_t plain;
      plain = mk_ret(8'h00, 1'b0, 1'b1, 1'b0, 1'b0, 32'h0);
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         axi_rd(8'(4 * i), d, rs);
         check(d, 32'h0);
      end
      core_u.do_fetch(32'h0);
      #1 no_exc();
      axi_rd(8'h18, d, rs);
      check({30'h0, rs}, {30'h0, RESP_SLVERR});
      axi_wr(8'h1C, rnd(), rs);
      check({30'h0, rs}, {30'h0, RESP_SLVERR});
      d = rnd();
      axi_wr(8'h0C, d, rs);
      axi_rd(8'h0C, a, rs);
      check(a, d);
      // opcode CC is never privilege checked, the soft interrupt is
      core_u.do_retire(mk_ret(BREAK_OPCODE, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0));
      #1 chk_exc(VEC_BREAK);
      check({31'h0, exc.priv_fault}, 32'h0);
      for (int k = 0; k < 2; k++)
      begin
         core_u.do_retire(mk_ret(8'h00, 1'b1, k[0], 1'b0, 1'b0, 32'h0));
         #1 chk_exc(k[0] ? VEC_BREAK : priv_vec);
         check({31'h0, exc.priv_fault}, {31'h0, !k[0]});
      end
      axi_wr(ADDR_STATUS, 32'h0, rs);
      core_u.do_retire(mk_ret(8'h00, 1'b0, 1'b1, 1'b0, 1'b1, rnd()));
      #1 no_exc();
      p = rnd();
      core_u.do_retire(mk_ret(8'h00, 1'b0, 1'b1, 1'b0, 1'b0, p));
      #1 chk_exc(VEC_DEBUG);
      check(exc.return_pointer, p);
      axi_rd(ADDR_STATUS, d, rs);
      check(d, 32'h1 << STATUS_STEP_BIT);
      // bp2 matches too but stays disabled
      a = rnd();
      axi_wr(ADDR_BP0, a, rs);
      axi_wr(ADDR_BP0 + 8'h08, a, rs);
      axi_wr(ADDR_CONTROL, 32'h2, rs);
      axi_wr(ADDR_STATUS, 32'h0, rs);
      core_u.do_fetch(a);
      #1 chk_exc(VEC_DEBUG);
      check({31'h0, exc.fault}, 32'h1);
      check(exc.return_pointer, a);
      axi_rd(ADDR_STATUS, d, rs);
      check(d, 32'h5);
      core_u.do_fetch(a + 32'h1);
      #1 no_exc();
      base = (rnd() & 32'h0FFF_FFF0) | 32'h5;
      axi_wr(ADDR_BP0 + 8'h04, base, rs);
      for (int l = 0; l < 4; l++)
      begin
         axi_wr(ADDR_CONTROL, 32'h30_0004 | (32'(l) << 22), rs);
         for (int o = 0; o < 12; o++)
         begin
            d = rnd();
            a = (base & ~32'h7) - 32'h2 + 32'(o);
            sz = {d[1] & d[0], d[0]};
            core_u.do_data(a, d[2], sz);
            core_u.do_retire(plain);
            #1;
            if (exp_hit(base, 2'(l), a, sz))
               chk_exc(VEC_DEBUG);
            else
               no_exc();
         end
      end
      // write-only qualifier ignores reads
      axi_wr(ADDR_CONTROL, 32'h10_0004, rs);
      for (int k = 0; k < 2; k++)
      begin
         core_u.do_data(base, k[0], 2'h0);
         core_u.do_retire(plain);
         #1;
         if (k[0])
            chk_exc(VEC_DEBUG);
         else
            no_exc();
      end
      axi_wr(ADDR_CONTROL, 32'h30_0004, rs);
      core_u.do_data(base, 1'b0, 2'h0);
      core_u.do_retire(mk_ret(BREAK_OPCODE, 1'b0, 1'b1, 1'b0, 1'b0, 32'h0));
      #1 chk_exc(VEC_DEBUG);
      @(posedge core_clk);
      #1 no_exc();
      axi_wr(ADDR_CONTROL, 32'h3FF, rs);
      core_u.do_retire(mk_ret(8'h00, 1'b0, 1'b1, 1'b1, 1'b0, 32'h0));
      axi_rd(ADDR_CONTROL, d, rs);
      check(d, 32'h2AA);
      summarize();
   end
endmodule // debug_breakpoint_unit_tb_top
`default_nettype wire
